// File: include/ppei_cfg.svh
// Purpose: Offsets, field positions and codes of the path event block
// Assumes: Included by its bare name wherever a constant is needed
// Notes: Register offsets are indices; byte address is four times each
`ifndef PPEI_CFG_SVH
`define PPEI_CFG_SVH

// ------------------------------------------------------------
// Register indices
// ------------------------------------------------------------
`define PPEI_IDX_PATH_STATE 6'h30
`define PPEI_IDX_PATH_STATUS 6'h31
`define PPEI_IDX_POINTER_STATUS 6'h32
`define PPEI_IDX_PATH_ENABLE 6'h33
`define PPEI_IDX_POINTER_ENABLE 6'h34
`define PPEI_IDX_POINTER_LOW 6'h35
`define PPEI_IDX_POINTER_CTRL 6'h36

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PPEI_BIT_FEBE 0
`define PPEI_BIT_BIP 1
`define PPEI_BIT_RDI 2
`define PPEI_BIT_AIS 3
`define PPEI_BIT_LOP 5
`define PPEI_BIT_PSL 7
`define PPEI_BIT_ERDI 0
`define PPEI_BIT_NDF 0
`define PPEI_BIT_PSE 1
`define PPEI_BIT_NSE 2
`define PPEI_BIT_ILLPTR 3
`define PPEI_BIT_INVNDF 4
`define PPEI_BIT_DISC 5
`define PPEI_BIT_ILLJREQ 7
`define PPEI_BIT_SHADOW_SEL 6
`define PPEI_PATH_MASK 8'hAF
`define PPEI_SHADOW_MASK 8'h01
`define PPEI_POINTER_MASK 8'hBF
`define PPEI_CTRL_MASK 8'hE0

// ------------------------------------------------------------
// Reset values and bus codes
// ------------------------------------------------------------
`define PPEI_ENABLE_RESET 8'h00
`define PPEI_CTRL_RESET 8'h00
`define PPEI_RESP_OKAY 2'b00
`define PPEI_RESP_SLVERR 2'b10

`endif

// File: include/ppei_pkg.sv
// Purpose: Types shared by the path event block
// Assumes: Line events arrive as one-cycle pulses, states as levels
// Notes: Constants live in ppei_cfg.svh
package ppei_pkg;

   // ---------------------------------------------------------
   // Overhead inputs from the receive path
   // ---------------------------------------------------------
   typedef struct packed {
      logic febe_event;
      logic b3_error;
      logic rdi_state;
      logic ais_state;
      logic lop_state;
      logic [7:0] signal_label;
      logic [2:0] erdi_state;
      logic ndf_active;
      logic pos_justify;
      logic neg_justify;
      logic illegal_pointer;
      logic ndf_strobe;
      logic [3:0] ndf_code;
      logic new_pointer;
      logic illegal_justify_request;
      logic [9:0] pointer_value;
      logic [1:0] ss_bits;
   } ppei_line_type;

   typedef logic [7:0] ppei_byte_type;

endpackage

// File: design/ppei_sticky.sv
// Purpose: Bank of sticky event flags, cleared by a read strobe
// Assumes: set and clear are synchronous to mclk
// Notes: A set in the clearing cycle wins so no event is lost
module ppei_sticky #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Events and acknowledge
   input wire logic [WIDTH-1:0] set,
   input wire logic clear,
   // Flags
   output logic [WIDTH-1:0] flags
);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= '0;
      end else begin
         flags <= (flags & ~{WIDTH{clear}}) | set;
      end
   end

endmodule

// File: design/ppei_top.sv
// Purpose: Path and pointer event flags, enables and interrupt output
// Assumes: AXI4-Lite slave, one write and one read in flight at most
// Notes: Byte address is register index times four; data in bits 7:0
//
// The AXI4-Lite register port was decided locally.
module ppei_top (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Receive path overhead
   input ppei_pkg::ppei_line_type line_in,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   // AXI4-Lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Interrupt
   output logic interrupt_out_n
);
   import ppei_pkg::*;
   `include "ppei_cfg.svh"

   // ---------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------
   function automatic logic [5:0] reg_index(input logic [7:0] addr);
      reg_index = addr[7:2];
   endfunction

   function automatic logic mapped(input logic [5:0] idx);
      mapped = (idx >= `PPEI_IDX_PATH_STATE) &&
               (idx <= `PPEI_IDX_POINTER_CTRL);
   endfunction

   function automatic logic bad_ndf(input logic [3:0] code);
      case (code)
         4'h0, 4'h3, 4'h5, 4'hA, 4'hC, 4'hF: bad_ndf = 1'b1;
         default: bad_ndf = 1'b0;
      endcase
   endfunction

   // ---------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------
   ppei_byte_type path_event_enable;
   ppei_byte_type path_shadow_event_enable;
   ppei_byte_type pointer_event_enable;
   ppei_byte_type pointer_ctrl;
   ppei_byte_type path_event_status;
   ppei_byte_type path_shadow_event_status;
   ppei_byte_type pointer_event_status;
   logic shadow_map_select;

   // ---------------------------------------------------------
   // Line state history for change detection
   // ---------------------------------------------------------
   logic primed;
   logic rdi_prev;
   logic ais_prev;
   logic lop_prev;
   logic [7:0] label_prev;
   logic [2:0] erdi_prev;

   // First cycle after reset only loads history, so reset levels do
   // not show up as false state changes
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         primed <= 1'b0;
         rdi_prev <= 1'b0;
         ais_prev <= 1'b0;
         lop_prev <= 1'b0;
         label_prev <= 8'h00;
         erdi_prev <= 3'h0;
      end else begin
         primed <= 1'b1;
         rdi_prev <= line_in.rdi_state;
         ais_prev <= line_in.ais_state;
         lop_prev <= line_in.lop_state;
         label_prev <= line_in.signal_label;
         erdi_prev <= line_in.erdi_state;
      end
   end

   // ---------------------------------------------------------
   // Event set vectors
   // ---------------------------------------------------------
   logic [7:0] path_set;
   logic [0:0] shadow_set;
   logic [7:0] pointer_set;

   always_comb begin
      path_set = 8'h00;
      path_set[`PPEI_BIT_FEBE] = line_in.febe_event;
      path_set[`PPEI_BIT_BIP] = line_in.b3_error;
      path_set[`PPEI_BIT_RDI] = primed &&
         (line_in.rdi_state != rdi_prev);
      path_set[`PPEI_BIT_AIS] = primed &&
         (line_in.ais_state != ais_prev);
      path_set[`PPEI_BIT_LOP] = primed &&
         (line_in.lop_state != lop_prev);
      path_set[`PPEI_BIT_PSL] = primed &&
         (line_in.signal_label != label_prev);
   end

   assign shadow_set[`PPEI_BIT_ERDI] = primed &&
      (line_in.erdi_state != erdi_prev);

   always_comb begin
      pointer_set = 8'h00;
      pointer_set[`PPEI_BIT_NDF] = line_in.ndf_active;
      pointer_set[`PPEI_BIT_PSE] = line_in.pos_justify;
      pointer_set[`PPEI_BIT_NSE] = line_in.neg_justify;
      pointer_set[`PPEI_BIT_ILLPTR] = line_in.illegal_pointer;
      pointer_set[`PPEI_BIT_INVNDF] = line_in.ndf_strobe &&
         bad_ndf(line_in.ndf_code);
      pointer_set[`PPEI_BIT_DISC] = line_in.new_pointer &&
         !line_in.ndf_active;
      pointer_set[`PPEI_BIT_ILLJREQ] =
         line_in.illegal_justify_request;
   end

   // ---------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------
   logic rd_take;
   logic [5:0] rd_idx;
   logic clear_path;
   logic clear_shadow;
   logic clear_pointer;
   ppei_byte_type rd_byte;

   assign arready = !rvalid;
   assign rd_take = arvalid && arready;
   assign rd_idx = reg_index(araddr);

   // Clear-on-read acts on the accepted read, with the flag value
   // sampled into rdata in the same edge
   assign clear_path = rd_take && !shadow_map_select &&
      (rd_idx == `PPEI_IDX_PATH_STATUS);
   assign clear_shadow = rd_take && shadow_map_select &&
      (rd_idx == `PPEI_IDX_PATH_STATUS);
   assign clear_pointer = rd_take &&
      (rd_idx == `PPEI_IDX_POINTER_STATUS);

   ppei_sticky #(
      .WIDTH(8)
   ) u_path_flags (
      .mclk(mclk),
      .rst_n(rst_n),
      .set(path_set),
      .clear(clear_path),
      .flags(path_event_status)
   );

   // One flag net, widened once, so the status byte has a single driver
   logic [0:0] shadow_flag;

   ppei_sticky #(
      .WIDTH(1)
   ) u_shadow_flags (
      .mclk(mclk),
      .rst_n(rst_n),
      .set(shadow_set),
      .clear(clear_shadow),
      .flags(shadow_flag)
   );
   assign path_shadow_event_status = {7'h00, shadow_flag};

   ppei_sticky #(
      .WIDTH(8)
   ) u_pointer_flags (
      .mclk(mclk),
      .rst_n(rst_n),
      .set(pointer_set),
      .clear(clear_pointer),
      .flags(pointer_event_status)
   );

   // Unused status positions read as zero
   always_comb begin
      rd_byte = 8'h00;
      case (rd_idx)
         `PPEI_IDX_PATH_STATE: begin
            if (shadow_map_select) begin
               rd_byte[2:0] = line_in.erdi_state;
            end else begin
               rd_byte[`PPEI_BIT_LOP] = line_in.lop_state;
               rd_byte[`PPEI_BIT_AIS] = line_in.ais_state;
               rd_byte[`PPEI_BIT_RDI] = line_in.rdi_state;
            end
         end
         `PPEI_IDX_PATH_STATUS: begin
            if (shadow_map_select) begin
               rd_byte = path_shadow_event_status;
            end else begin
               rd_byte = path_event_status & `PPEI_PATH_MASK;
            end
         end
         `PPEI_IDX_POINTER_STATUS: begin
            rd_byte = pointer_event_status & `PPEI_POINTER_MASK;
         end
         `PPEI_IDX_PATH_ENABLE: begin
            if (shadow_map_select) begin
               rd_byte = path_shadow_event_enable;
            end else begin
               rd_byte = path_event_enable;
            end
         end
         `PPEI_IDX_POINTER_ENABLE: begin
            rd_byte = pointer_event_enable;
         end
         `PPEI_IDX_POINTER_LOW: begin
            rd_byte = line_in.pointer_value[7:0];
         end
         `PPEI_IDX_POINTER_CTRL: begin
            rd_byte = pointer_ctrl & `PPEI_CTRL_MASK;
            rd_byte[3:2] = line_in.ss_bits;
            rd_byte[1:0] = line_in.pointer_value[9:8];
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `PPEI_RESP_OKAY;
      end else if (rd_take) begin
         rvalid <= 1'b1;
         rdata <= {24'h00_0000, rd_byte};
         rresp <= mapped(rd_idx) ? `PPEI_RESP_OKAY : `PPEI_RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------
   // Write channel
   // ---------------------------------------------------------
   logic aw_held;
   logic w_held;
   logic [5:0] wr_idx;
   ppei_byte_type wr_byte;
   logic wr_lane;
   logic do_write;

   assign awready = !aw_held && !bvalid;
   assign wready = !w_held && !bvalid;
   assign do_write = aw_held && w_held && !bvalid;

   // Address and data are caught apart so either may come first
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         wr_idx <= 6'h00;
      end else if (awvalid && awready) begin
         aw_held <= 1'b1;
         wr_idx <= reg_index(awaddr);
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         w_held <= 1'b0;
         wr_byte <= 8'h00;
         wr_lane <= 1'b0;
      end else if (wvalid && wready) begin
         w_held <= 1'b1;
         wr_byte <= wdata[7:0];
         wr_lane <= wstrb[0];
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid <= 1'b0;
         bresp <= `PPEI_RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp <= mapped(wr_idx) ? `PPEI_RESP_OKAY : `PPEI_RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Reserved path and pointer enable bits are stored as written (the shadow ones are dropped); only defined bits
   // reach the interrupt, so a stray one cannot raise it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         path_event_enable <= `PPEI_ENABLE_RESET;
         path_shadow_event_enable <= `PPEI_ENABLE_RESET;
         pointer_event_enable <= `PPEI_ENABLE_RESET;
      end else if (do_write && wr_lane) begin
         if (wr_idx == `PPEI_IDX_PATH_ENABLE) begin
            if (shadow_map_select) begin
               path_shadow_event_enable <=
                  wr_byte & `PPEI_SHADOW_MASK;
            end else begin
               path_event_enable <= wr_byte;
            end
         end
         if (wr_idx == `PPEI_IDX_POINTER_ENABLE) begin
            pointer_event_enable <= wr_byte;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pointer_ctrl <= `PPEI_CTRL_RESET;
      end else if (do_write && wr_lane &&
                   wr_idx == `PPEI_IDX_POINTER_CTRL) begin
         pointer_ctrl <= wr_byte & `PPEI_CTRL_MASK;
      end
   end

   assign shadow_map_select = pointer_ctrl[`PPEI_BIT_SHADOW_SEL];

   // ---------------------------------------------------------
   // Interrupt output
   // ---------------------------------------------------------
   logic path_pending;
   logic shadow_pending;
   logic pointer_pending;

   assign path_pending = |(path_event_status & path_event_enable &
      `PPEI_PATH_MASK);
   assign shadow_pending = path_shadow_event_status[`PPEI_BIT_ERDI] &&
      path_shadow_event_enable[`PPEI_BIT_ERDI];
   assign pointer_pending = |(pointer_event_status &
      pointer_event_enable & `PPEI_POINTER_MASK);

   // Registered so the pin never glitches on status decode
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_out_n <= 1'b1;
      end else begin
         interrupt_out_n <= !(path_pending || shadow_pending ||
            pointer_pending);
      end
   end

endmodule

// File: bench/ppei_line_model.sv
// Purpose: Receive line model feeding overhead events to the block
// Assumes: Called just after a rising edge of mclk
// Notes: Pulses idle low; state changes persist until toggled back
module ppei_line_model (
   // Clock
   input wire logic mclk,
   // Overhead towards the block
   output ppei_pkg::ppei_line_type line_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import ppei_pkg::*;

   initial line_in = '0;

   task automatic set_pointer(input logic [9:0] v);
      @(posedge mclk);
      line_in.pointer_value <= v;
   endtask

   // One event per call, two in the default case (new_pointer with ndf_active); levels keep their new value afterwards
   task automatic cause(input int ev, input logic [3:0] code);
      ppei_line_type p;
      ppei_line_type q;
      @(posedge mclk);
      q = line_in;
      p = q;
      case (ev)
         0: p.febe_event = 1'b1;
         1: p.b3_error = 1'b1;
         2: p.rdi_state = ~q.rdi_state;
         3: p.ais_state = ~q.ais_state;
         4: p.lop_state = ~q.lop_state;
         5: p.signal_label = q.signal_label + 8'h01;
         6: p.erdi_state = q.erdi_state + 3'h1;
         7: p.ndf_active = 1'b1;
         8: p.pos_justify = 1'b1;
         9: p.neg_justify = 1'b1;
         10: p.illegal_pointer = 1'b1;
         11: begin
            p.ndf_strobe = 1'b1;
            p.ndf_code = code;
         end
         12: p.new_pointer = 1'b1;
         13: p.illegal_justify_request = 1'b1;
         default: begin
            p.new_pointer = 1'b1;
            p.ndf_active = 1'b1;
         end
      endcase
      if (ev >= 2 && ev <= 6) q = p;
      line_in <= p;
      @(posedge mclk);
      line_in <= q;
   endtask
endmodule

// File: bench/ppei_chk.sv
// Purpose: Port-level checks of the path event block
// Assumes: Bound to ppei_top; flags are internal and unseen
// Notes: Read data and responses are tied to the request cycle
`include "ppei_cfg.svh"
module ppei_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Line side
   input ppei_pkg::ppei_line_type line_in,
   // Bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [7:0] araddr,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   // Interrupt
   input wire logic interrupt_out_n
);
   timeunit 1ns;
   timeprecision 1ps;
   import ppei_pkg::*;
   localparam logic [7:0] A_PLO = {`PPEI_IDX_POINTER_LOW, 2'b00};
   wire ar_go = arvalid && arready;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------
   // Bus answers
   // ----------------------------------------
   rd_answer_a: assert property (ar_go |=> rvalid)
      else $error("read not answered");
   rd_hold_a: assert property (rvalid && !rready |=>
      rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer dropped");
   wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   wr_answer_a: assert property (awvalid && awready && wvalid && wready
      |-> ##2 bvalid) else $error("write answer late");
   busy_block_a: assert property (!(bvalid && (awready || wready)) &&
      !(rvalid && arready)) else $error("request taken while busy");
   bad_addr_a: assert property (ar_go && (araddr[7:2] < 6'h30 ||
      araddr[7:2] > 6'h36) |=> rresp == `PPEI_RESP_SLVERR && rdata == '0)
      else $error("unmapped read not refused");
   pointer_low_a: assert property (ar_go && araddr == A_PLO |=>
      rdata == {24'h00_0000, $past(line_in.pointer_value[7:0])})
      else $error("pointer low byte wrong");
   upper_zero_a: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
      else $error("upper read bits set");

   cover property (ar_go);
   cover property (bvalid && bready);
   cover property ($fell(interrupt_out_n));
endmodule

bind ppei_top ppei_chk ppei_chk_i (.mclk(mclk), .rst_n(rst_n),
   .line_in(line_in), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
   .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
   .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
   .interrupt_out_n(interrupt_out_n));

// File: bench/ppei_top_bench.sv
// Purpose: Self-checking bench of the path event block
// Assumes: Line side comes from ppei_line_model
// Notes: Byte address is register index times four
`include "ppei_cfg.svh"
module ppei_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import ppei_pkg::*;
   localparam logic [7:0] A_PST = {`PPEI_IDX_PATH_STATUS, 2'b00};
   localparam logic [7:0] A_QST = {`PPEI_IDX_POINTER_STATUS, 2'b00};
   localparam logic [7:0] A_PEN = {`PPEI_IDX_PATH_ENABLE, 2'b00};
   localparam logic [7:0] A_QEN = {`PPEI_IDX_POINTER_ENABLE, 2'b00};
   localparam logic [7:0] A_PLO = {`PPEI_IDX_POINTER_LOW, 2'b00};
   localparam logic [7:0] A_CTL = {`PPEI_IDX_POINTER_CTRL, 2'b00};
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, interrupt_out_n;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   ppei_line_type line_in;
   int bad_count = 0;
   int num_checks = 0;

   always #10 mclk = ~mclk;

   ppei_line_model ppei_line_model_i (.mclk(mclk), .line_in(line_in));
   ppei_top ppei_top_i (.mclk(mclk), .rst_n(rst_n), .line_in(line_in),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .interrupt_out_n(interrupt_out_n));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic guard(inout int n);
      n++;
      if (n > 100) begin
         bad_count++;
         print_verdict();
      end
   endtask

   // Handshake seen at the falling edge, since inputs only move after rise
   task automatic wrchk(input logic [7:0] a, input logic [7:0] d,
         input logic [1:0] r = `PPEI_RESP_OKAY);
      logic pa, pw, ta, tw, tb;
      logic [1:0] s;
      int n;
      pa = 1'b1;
      pw = 1'b1;
      tb = 1'b0;
      n = 0;
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= {24'h00_0000, d};
      wstrb <= 4'hF;
      bready <= 1'b1;
      while (!tb) begin
         @(negedge mclk);
         ta = awready;
         tw = wready;
         tb = bvalid;
         s = bresp;
         @(posedge mclk);
         if (pa && ta) begin
            pa = 1'b0;
            awvalid <= 1'b0;
         end
         if (pw && tw) begin
            pw = 1'b0;
            wvalid <= 1'b0;
         end
         guard(n);
      end
      bready <= 1'b0;
      // One idle edge so a following call never re-drives bready now
      @(posedge mclk);
      chk({30'h0, s}, {30'h0, r});
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] m,
         input logic [7:0] e, input logic [1:0] r = `PPEI_RESP_OKAY);
      logic pa, ta, tv;
      logic [31:0] d;
      logic [1:0] s;
      int n;
      pa = 1'b1;
      tv = 1'b0;
      n = 0;
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      while (!tv) begin
         @(negedge mclk);
         ta = arready;
         tv = rvalid;
         d = rdata;
         s = rresp;
         @(posedge mclk);
         if (pa && ta) begin
            pa = 1'b0;
            arvalid <= 1'b0;
         end
         guard(n);
      end
      rready <= 1'b0;
      @(posedge mclk);
      chk({22'h0, s, d[7:0] & m}, {22'h0, r, e});
   endtask

   task automatic irqchk(input logic e);
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk({31'h0, interrupt_out_n}, {31'h0, e});
      @(posedge mclk);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      rdchk(A_PEN, 8'hFF, `PPEI_ENABLE_RESET);
      rdchk(A_QEN, 8'hFF, `PPEI_ENABLE_RESET);
      rdchk(A_CTL, 8'hE0, `PPEI_CTRL_RESET);
      rdchk(8'h00, 8'hFF, 8'h00, `PPEI_RESP_SLVERR);
      rdchk(8'hDC, 8'hFF, 8'h00, `PPEI_RESP_SLVERR);
      wrchk(8'hFC, 8'h00, `PPEI_RESP_SLVERR);
   endtask

   task automatic t_pointer;
      ppei_line_model_i.set_pointer(10'h2A5);
      rdchk(A_PLO, 8'hFF, 8'hA5);
      rdchk(A_CTL, 8'h1F, 8'h02);
   endtask

   // Each event: set while masked, cleared by read, then gated to irq
   task automatic t_events;
      int bpos[14] = '{0, 1, 2, 3, 5, 7, 0, 0, 1, 2, 3, 4, 5, 7};
      logic [7:0] en, st, b;
      for (int i = 0; i < 14; i++) begin
         en = (i < 7) ? A_PEN : A_QEN;
         st = (i < 7) ? A_PST : A_QST;
         b = 8'h01 << bpos[i];
         if (i == 6) wrchk(A_CTL, 8'h40);
         ppei_line_model_i.cause(i, 4'h0);
         irqchk(1'b1);
         rdchk(st, 8'hFF, b);
         rdchk(st, 8'hFF, 8'h00);
         wrchk(en, b);
         rdchk(en, 8'hFF, b);
         ppei_line_model_i.cause(i, 4'h0);
         irqchk(1'b0);
         rdchk(st, 8'hFF, b);
         irqchk(1'b1);
         wrchk(en, 8'h00);
         if (i == 6) wrchk(A_CTL, 8'h00);
      end
   endtask

   task automatic t_codes;
      logic [7:0] e;
      for (int c = 0; c < 16; c++) begin
         ppei_line_model_i.cause(11, c[3:0]);
         e = (c inside {0, 3, 5, 10, 12, 15}) ? 8'h10 : 8'h00;
         rdchk(A_QST, 8'hFF, e);
      end
      ppei_line_model_i.cause(14, 4'h0);
      rdchk(A_QST, 8'hFF, 8'h01);
   endtask

   // Reset in mid-run clears enables, flags and the interrupt
   task automatic t_midreset;
      wrchk(A_QEN, 8'h01);
      ppei_line_model_i.cause(7, 4'h0);
      irqchk(1'b0);
      rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      irqchk(1'b1);
      rdchk(A_QST, 8'hFF, 8'h00);
      t_reset();
   endtask

   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_pointer();
      t_events();
      t_codes();
      t_midreset();
      print_verdict();
   end
endmodule
